/* core/motor_cmd_slave.sv */
module motor_cmd_slave (
    input wire logic pclk,
    input wire logic presetn,
    lin_frame_if.slave link,
    input wire logic [6:0] physical_address,
    input wire logic [15:0] actual_position,
    input wire logic target_reached,
    input wire logic positioning_request,
    output logic positioning_grant,
    output logic [3:0] run_current,
    output logic [3:0] hold_current,
    output logic [3:0] max_velocity,
    output logic [3:0] min_velocity,
    output logic [10:0] secure_position,
    output logic direction_invert,
    output logic [3:0] acceleration,
    output logic accel_shape,
    output logic [1:0] microstep_resolution,
    output logic restore_done,
    output logic reference_run_active,
    output logic reference_lockup,
    output logic [15:0] reference_target,
    output logic [3:0] reference_max_velocity,
    output logic [3:0] reference_min_velocity,
    output logic reference_constant_speed,
    output logic otp_busy,
    output logic [7:0] otp_zapped,
    output logic [lin_cmd_pkg::FRAME_BITS-1:0] otp_image
);
    import lin_cmd_pkg::*;

    // ------------------------------------------------------------
    // frame decode
    // ------------------------------------------------------------
    logic [7:0] d [FRAME_BYTES];
    logic ready_reg;
    logic taken;
    logic is_diag;
    logic [7:0] addr_byte;
    logic addressed;
    logic hit_restore;
    logic hit_run;
    logic hit_param;
    logic hit_otp;

    genvar gi;
    generate
        for (gi = 0; gi < FRAME_BYTES; gi++) begin : g_bytes
            assign d[gi] = link.frame_data[FRAME_BITS-1-8*gi -: 8];
        end
    endgenerate

    assign taken = link.frame_valid && ready_reg;
    assign is_diag = (link.frame_id == ID_DIAG) && (d[0] == APP_CMD_BYTE);
    assign addr_byte = is_diag ? d[2] : d[1];
    assign addressed = !addr_byte[BROAD_BIT] || (addr_byte[6:0] == physical_address);
    assign hit_restore = taken && addressed && (link.frame_id != ID_DIAG)
        && (d[0] == CMD_RESTORE);
    assign hit_run = taken && addressed && is_diag && (d[1] == CMD_REF_RUN);
    assign hit_param = taken && addressed && is_diag && (d[1] == CMD_PARAM);
    assign hit_otp = taken && addressed && is_diag && (d[1] == CMD_OTP)
        && (d[3][7:3] == OTP_ADDR_ONES) && (d[5] == FILL_BYTE)
        && (d[6] == FILL_BYTE) && (d[7] == FILL_BYTE);

    // ------------------------------------------------------------
    // ram parameters
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            run_current <= RST_RUN_CURRENT;
            hold_current <= RST_HOLD_CURRENT;
            max_velocity <= RST_MAX_VELOCITY;
            min_velocity <= RST_MIN_VELOCITY;
            secure_position <= RST_SECURE_POSITION;
            direction_invert <= RST_DIRECTION_INVERT;
            acceleration <= RST_ACCELERATION;
            accel_shape <= RST_ACCEL_SHAPE;
            microstep_resolution <= RST_MICROSTEP;
        end else if (hit_restore) begin
            // actual and target positions live in the controller and are not touched here; secure_position is reset
            run_current <= RST_RUN_CURRENT;
            hold_current <= RST_HOLD_CURRENT;
            max_velocity <= RST_MAX_VELOCITY;
            min_velocity <= RST_MIN_VELOCITY;
            secure_position <= RST_SECURE_POSITION;
            direction_invert <= RST_DIRECTION_INVERT;
            acceleration <= RST_ACCELERATION;
            accel_shape <= RST_ACCEL_SHAPE;
            microstep_resolution <= RST_MICROSTEP;
        end else if (hit_param) begin
            // applied at once, even during a motion
            run_current <= d[3][7:4];
            hold_current <= d[3][3:0];
            max_velocity <= d[4][7:4];
            min_velocity <= d[4][3:0];
            secure_position <= {d[5][7:5], d[6]};
            direction_invert <= d[5][4];
            acceleration <= d[5][3:0];
            accel_shape <= d[7][4];
            microstep_resolution <= d[7][3:2];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            restore_done <= 1'b0;
        end else begin
            restore_done <= hit_restore;
        end
    end

    // ------------------------------------------------------------
    // reference run sequencer
    // ------------------------------------------------------------
    run_state_e run_state_reg;
    logic [15:0] second_target_reg;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            run_state_reg <= RUN_IDLE;
            reference_target <= 16'h0000;
            second_target_reg <= 16'h0000;
            reference_max_velocity <= 4'h0;
            reference_min_velocity <= 4'h0;
            reference_constant_speed <= 1'b0;
        end else begin
            case (run_state_reg)
                RUN_IDLE: begin
                    if (hit_run) begin
                        reference_target <= {d[4], d[5]};
                        second_target_reg <= {d[6], d[7]};
                        reference_max_velocity <= d[3][7:4];
                        reference_min_velocity <= d[3][3:0];
                        reference_constant_speed <= 1'b0;
                        if (actual_position == {d[4], d[5]}) begin
                            run_state_reg <= RUN_LOCKED;
                        end else begin
                            run_state_reg <= RUN_FIRST;
                        end
                    end
                end
                RUN_FIRST: begin
                    if (target_reached) begin
                        if (second_target_reg == reference_target) begin
                            run_state_reg <= RUN_LOCKED;
                        end else begin
                            reference_target <= second_target_reg;
                            reference_constant_speed <= 1'b1;
                            run_state_reg <= RUN_SECOND;
                        end
                    end
                end
                RUN_SECOND: begin
                    if (target_reached) begin
                        reference_constant_speed <= 1'b0;
                        run_state_reg <= RUN_IDLE;
                    end
                end
                RUN_LOCKED: begin
                    run_state_reg <= RUN_LOCKED;
                end
                default: begin
                    run_state_reg <= RUN_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            reference_run_active <= 1'b0;
            reference_lockup <= 1'b0;
        end else begin
            reference_run_active <= (run_state_reg == RUN_FIRST) || (run_state_reg == RUN_SECOND);
            reference_lockup <= (run_state_reg == RUN_LOCKED);
        end
    end

    // other positioning commands are held off while the run is underway
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            positioning_grant <= 1'b0;
        end else begin
            positioning_grant <= positioning_request && (run_state_reg == RUN_IDLE) && !hit_run;
        end
    end

    // ------------------------------------------------------------
    // otp program and zap
    // ------------------------------------------------------------
    logic [7:0] otp_mem [OTP_BYTES];
    logic [3:0] zap_count_reg;

    generate
        for (gi = 0; gi < OTP_BYTES; gi++) begin : g_otp
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    otp_mem[gi] <= 8'h00;
                    otp_zapped[gi] <= 1'b0;
                end else if (hit_otp && (d[3][2:0] == 3'(gi)) && !otp_zapped[gi]) begin
                    otp_mem[gi] <= d[4];
                    otp_zapped[gi] <= 1'b1;
                end
            end
            assign otp_image[FRAME_BITS-1-8*gi -: 8] = otp_mem[gi];
        end
    endgenerate

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            zap_count_reg <= 4'h0;
            otp_busy <= 1'b0;
        end else if (hit_otp) begin
            zap_count_reg <= ZAP_CYCLES;
            otp_busy <= 1'b1;
        end else if (zap_count_reg != 4'h0) begin
            zap_count_reg <= zap_count_reg - 4'h1;
            otp_busy <= (zap_count_reg != 4'h1);
        end
    end

    // ------------------------------------------------------------
    // link handshake: one frame per ready cycle, stalled while zapping
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ready_reg <= 1'b0;
        end else begin
            ready_reg <= !hit_otp && !(otp_busy && zap_count_reg != 4'h1) && !taken;
        end
    end

    assign link.frame_ready = ready_reg;
endmodule

/* core/lin_cmd_pkg.sv */
package lin_cmd_pkg;
    // ------------------------------------------------------------
    // frame identifiers and command bytes
    // ------------------------------------------------------------
    localparam logic [5:0] ID_DIAG = 6'h3C;
    localparam logic [5:0] ID_GENERAL = 6'h10;
    localparam logic [7:0] APP_CMD_BYTE = 8'h80;
    localparam logic [7:0] CMD_RESTORE = 8'h87;
    localparam logic [7:0] CMD_REF_RUN = 8'h88;
    localparam logic [7:0] CMD_PARAM = 8'h89;
    localparam logic [7:0] CMD_OTP = 8'h90;
    localparam logic [7:0] FILL_BYTE = 8'hFF;
    localparam logic [4:0] OTP_ADDR_ONES = 5'h1F;
    localparam int BROAD_BIT = 7;

    // ------------------------------------------------------------
    // frame data layout: data1 in the top byte, data8 in the bottom
    // ------------------------------------------------------------
    localparam int FRAME_BYTES = 8;
    localparam int FRAME_BITS = 64;
    typedef logic [FRAME_BITS-1:0] frame_t;

    // ------------------------------------------------------------
    // ram parameter reset values
    // ------------------------------------------------------------
    localparam logic [3:0] RST_RUN_CURRENT = 4'h0;
    localparam logic [3:0] RST_HOLD_CURRENT = 4'h0;
    localparam logic [3:0] RST_MAX_VELOCITY = 4'h1;
    localparam logic [3:0] RST_MIN_VELOCITY = 4'h1;
    localparam logic [10:0] RST_SECURE_POSITION = 11'h400;
    localparam logic RST_DIRECTION_INVERT = 1'b0;
    localparam logic [3:0] RST_ACCELERATION = 4'h0;
    localparam logic RST_ACCEL_SHAPE = 1'b0;
    localparam logic [1:0] RST_MICROSTEP = 2'h0;

    // ------------------------------------------------------------
    // otp programming
    // ------------------------------------------------------------
    localparam int OTP_BYTES = 8;
    localparam logic [3:0] ZAP_CYCLES = 4'h8;

    // ------------------------------------------------------------
    // reference run states (gray along idle-first-second)
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        RUN_IDLE = 2'b00,
        RUN_FIRST = 2'b01,
        RUN_SECOND = 2'b11,
        RUN_LOCKED = 2'b10
    } run_state_e;

    // ------------------------------------------------------------
    // master command kinds and apb register map
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        KIND_RESTORE = 2'b00,
        KIND_REF_RUN = 2'b01,
        KIND_PARAM = 2'b11,
        KIND_OTP = 2'b10
    } cmd_kind_e;

    localparam logic [7:0] REG_CMD = 8'h00;
    localparam logic [7:0] REG_ARG = 8'h04;
    localparam logic [7:0] REG_ARG2 = 8'h08;
    localparam logic [7:0] REG_STATUS = 8'h0C;
    localparam int CMD_START_BIT = 31;
    localparam int CMD_NODE_LSB = 8;
    localparam int CMD_BROAD_BIT = 7;
endpackage

/* core/lin_frame_if.sv */
interface lin_frame_if;
    import lin_cmd_pkg::*;
    logic frame_valid;
    logic frame_ready;
    logic [5:0] frame_id;
    frame_t frame_data;

    modport master (output frame_valid, output frame_id, output frame_data, input frame_ready);
    modport slave (input frame_valid, input frame_id, input frame_data, output frame_ready);
endinterface

/* core/lin_cmd_master.sv */
module lin_cmd_master (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    lin_frame_if.master link,
    input wire logic motion_running,
    input wire logic [15:0] actual_position
);
    import lin_cmd_pkg::*;
    localparam logic [31:0] SHADOW_DEFAULT = {RST_RUN_CURRENT, RST_HOLD_CURRENT, RST_MAX_VELOCITY,
        RST_MIN_VELOCITY, RST_SECURE_POSITION[10:8], RST_DIRECTION_INVERT, RST_ACCELERATION,
        RST_SECURE_POSITION[7:0]};
    localparam logic [7:0] SHADOW2_DEFAULT = {3'b111, RST_ACCEL_SHAPE, RST_MICROSTEP, 2'b11};

    // ------------------------------------------------------------
    // apb registers
    // ------------------------------------------------------------
    logic [31:0] cmd_reg;
    logic [31:0] arg_reg;
    logic [7:0] arg2_reg;
    logic refused_reg;
    logic valid_reg;
    logic [5:0] id_reg;
    frame_t data_reg;
    logic [31:0] shadow_reg;
    logic [7:0] shadow2_reg;
    logic wr;
    logic start;
    logic refuse;
    logic [7:0] addr_byte;
    cmd_kind_e kind;
    logic mapped;

    assign wr = psel && penable && pwrite;
    assign start = wr && (paddr == REG_CMD) && pwdata[CMD_START_BIT];
    assign kind = cmd_kind_e'(pwdata[1:0]);
    assign addr_byte = {pwdata[CMD_BROAD_BIT], pwdata[CMD_NODE_LSB +: 7]};
    assign mapped = (paddr == REG_CMD) || (paddr == REG_ARG) || (paddr == REG_ARG2)
        || (paddr == REG_STATUS);
    assign refuse = valid_reg
        || ((kind == KIND_RESTORE) && motion_running)
        || ((kind == KIND_REF_RUN) && ((arg_reg[23:8] == actual_position)
        || (arg_reg[23:8] == {arg_reg[7:0], arg2_reg})));

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmd_reg <= 32'h0000_0000;
            arg_reg <= 32'h0000_0000;
            arg2_reg <= 8'h00;
            refused_reg <= 1'b0;
        end else if (wr) begin
            if (paddr == REG_CMD) begin
                cmd_reg <= pwdata;
                refused_reg <= pwdata[CMD_START_BIT] && refuse;
            end
            if (paddr == REG_ARG) begin
                arg_reg <= pwdata;
            end
            if (paddr == REG_ARG2) begin
                arg2_reg <= pwdata[7:0];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel && !penable;
            pslverr <= psel && !penable && !mapped;
            case (paddr)
                REG_CMD: prdata <= {1'b0, cmd_reg[30:0]};
                REG_ARG: prdata <= arg_reg;
                REG_ARG2: prdata <= {24'h00_0000, arg2_reg};
                REG_STATUS: prdata <= {30'h0000_0000, refused_reg, valid_reg};
                default: prdata <= 32'h0000_0000;
            endcase
        end
    end

    // ------------------------------------------------------------
    // frame builder
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            valid_reg <= 1'b0;
            id_reg <= 6'h00;
            data_reg <= '0;
            shadow_reg <= SHADOW_DEFAULT;
            shadow2_reg <= SHADOW2_DEFAULT;
        end else if (start && !refuse) begin
            valid_reg <= 1'b1;
            case (kind)
                KIND_RESTORE: begin
                    id_reg <= ID_GENERAL;
                    data_reg <= {CMD_RESTORE, addr_byte, {6{FILL_BYTE}}};
                    // the far end reloads its defaults, so mid-motion writes must resend them
                    shadow_reg <= SHADOW_DEFAULT;
                    shadow2_reg <= SHADOW2_DEFAULT;
                end
                KIND_REF_RUN: begin
                    id_reg <= ID_DIAG;
                    data_reg <= {APP_CMD_BYTE, CMD_REF_RUN, addr_byte, arg_reg, arg2_reg};
                end
                KIND_PARAM: begin
                    id_reg <= ID_DIAG;
                    if (motion_running) begin
                        // only the velocity byte may change mid-motion
                        data_reg <= {APP_CMD_BYTE, CMD_PARAM, addr_byte, shadow_reg[31:24],
                            arg_reg[23:16], shadow_reg[15:0], shadow2_reg};
                        shadow_reg[23:16] <= arg_reg[23:16];
                    end else begin
                        data_reg <= {APP_CMD_BYTE, CMD_PARAM, addr_byte, arg_reg,
                            arg2_reg};
                        shadow_reg <= arg_reg;
                        shadow2_reg <= arg2_reg;
                    end
                end
                default: begin
                    id_reg <= ID_DIAG;
                    data_reg <= {APP_CMD_BYTE, CMD_OTP, addr_byte, OTP_ADDR_ONES,
                        arg_reg[26:24], arg_reg[23:16], {3{FILL_BYTE}}};
                end
            endcase
        end else if (valid_reg && link.frame_ready) begin
            valid_reg <= 1'b0;
        end
    end

    assign link.frame_valid = valid_reg;
    assign link.frame_id = id_reg;
    assign link.frame_data = data_reg;
endmodule

/* verif/lin_link_props.sv */
module lin_link_props (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic frame_valid,
    input wire logic frame_ready,
    input wire logic [5:0] frame_id,
    input wire lin_cmd_pkg::frame_t frame_data
);
    timeunit 1ns;
    timeprecision 1ps;
    import lin_cmd_pkg::*;
    logic diag;
    logic take;
    assign diag = frame_valid && frame_id == ID_DIAG;
    assign take = frame_valid && frame_ready;
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    // --------------------------------------------
    // link handshake and frame layout
    // --------------------------------------------
    hold_request_a: assert property (frame_valid && !frame_ready |=> frame_valid
        && $stable(frame_data) && $stable(frame_id)) else $error("frame changed before taken");
    valid_drop_a: assert property (take |=> !frame_valid) else $error("valid kept after take");
    ready_gap_a: assert property (take |=> !frame_ready) else $error("ready kept after take");
    restore_code_a: assert property (frame_valid && !diag
        |-> frame_data[63:56] == CMD_RESTORE) else $error("general frame without restore code");
    diag_head_a: assert property (diag |-> frame_data[63:56] == APP_CMD_BYTE
        && frame_data[55] == 1'b1) else $error("diag frame head wrong");
    target_differ_a: assert property (diag && frame_data[55:48] == CMD_REF_RUN
        |-> frame_data[31:16] != frame_data[15:0]) else $error("equal reference targets");
    param_ones_a: assert property (diag && frame_data[55:48] == CMD_PARAM
        |-> frame_data[7:5] == 3'b111 && frame_data[1:0] == 2'b11)
        else $error("param data8 ones wrong");
    otp_fill_a: assert property (diag && frame_data[55:48] == CMD_OTP
        |-> frame_data[39:35] == OTP_ADDR_ONES && frame_data[23:0] == {3{FILL_BYTE}})
        else $error("otp fill wrong");
    zap_wait_a: assert property (take && diag && frame_data[55:48] == CMD_OTP
        |=> (!frame_ready) [*8]) else $error("ready back during zap");
endmodule

/* verif/test_lin_motor_command_decoder.sv */
module test_lin_motor_command_decoder;
    timeunit 1ns;
    timeprecision 1ps;
    import lin_cmd_pkg::*;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic target_reached = 0, positioning_request = 0, motion_running = 0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [6:0] physical_address = 7'h15;
    logic [15:0] actual_position = 16'h0100, reference_target;
    logic pready, pslverr, err, positioning_grant, direction_invert, accel_shape;
    logic restore_done, reference_run_active, reference_lockup, reference_constant_speed;
    logic otp_busy;
    logic [3:0] run_current, hold_current, max_velocity, min_velocity, acceleration;
    logic [3:0] reference_max_velocity, reference_min_velocity;
    logic [10:0] secure_position;
    logic [1:0] microstep_resolution;
    logic [7:0] otp_zapped;
    logic [63:0] otp_image;
    logic [34:0] prm, rst_prm;
    int mismatches = 0, tests_run = 0, cycles = 0, restores = 0;
    assign prm = {run_current, hold_current, max_velocity, min_velocity, secure_position,
        direction_invert, acceleration, accel_shape, microstep_resolution};
    assign rst_prm = {RST_RUN_CURRENT, RST_HOLD_CURRENT, RST_MAX_VELOCITY, RST_MIN_VELOCITY,
        RST_SECURE_POSITION, RST_DIRECTION_INVERT, RST_ACCELERATION, RST_ACCEL_SHAPE,
        RST_MICROSTEP};
    always #2 pclk = ~pclk;
    lin_frame_if link();
    motor_cmd_slave u_motor_cmd_slave (.pclk(pclk), .presetn(presetn), .link(link),
        .physical_address(physical_address), .actual_position(actual_position),
        .target_reached(target_reached), .positioning_request(positioning_request),
        .positioning_grant(positioning_grant), .run_current(run_current),
        .hold_current(hold_current), .max_velocity(max_velocity), .min_velocity(min_velocity),
        .secure_position(secure_position), .direction_invert(direction_invert),
        .acceleration(acceleration), .accel_shape(accel_shape),
        .microstep_resolution(microstep_resolution), .restore_done(restore_done),
        .reference_run_active(reference_run_active), .reference_lockup(reference_lockup),
        .reference_target(reference_target), .reference_max_velocity(reference_max_velocity),
        .reference_min_velocity(reference_min_velocity),
        .reference_constant_speed(reference_constant_speed), .otp_busy(otp_busy),
        .otp_zapped(otp_zapped), .otp_image(otp_image));
    lin_cmd_master u_lin_cmd_master (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .link(link), .motion_running(motion_running),
        .actual_position(actual_position));
    lin_link_props u_lin_link_props (.pclk(pclk), .presetn(presetn),
        .frame_valid(link.frame_valid), .frame_ready(link.frame_ready),
        .frame_id(link.frame_id), .frame_data(link.frame_data));
    // --------------------------------------------
    // bus and compare helpers
    // --------------------------------------------
    task close_out;
        if (mismatches == 0 && tests_run > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task chk(input logic [63:0] got, input logic [63:0] exp);
        tests_run++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task issue(input logic [1:0] k, input logic b, input logic [6:0] n,
        input logic [31:0] a, input logic [31:0] a2);
        apb(1'b1, REG_ARG, a);
        apb(1'b1, REG_ARG2, a2);
        apb(1'b1, REG_CMD, {1'b1, 16'h0000, n, b, 5'h00, k});
    endtask
    task send(input logic [1:0] k, input logic b, input logic [6:0] n,
        input logic [31:0] a, input logic [31:0] a2);
        issue(k, b, n, a, a2);
        apb(1'b0, REG_STATUS, 32'h0);
        while (rd[0] !== 1'b0) apb(1'b0, REG_STATUS, 32'h0);
        repeat (2) @(posedge pclk);
    endtask
    task refused(input logic [1:0] k, input logic [31:0] a, input logic [31:0] a2);
        issue(k, 1'b1, 7'h15, a, a2);
        apb(1'b0, REG_STATUS, 32'h0);
        chk(64'(rd[1]), 64'h1);
    endtask
    task pulse(input logic tgt);
        @(posedge pclk);
        if (tgt) target_reached <= 1'b1;
        else positioning_request <= 1'b1;
        @(posedge pclk);
        target_reached <= 1'b0;
        positioning_request <= 1'b0;
        @(posedge pclk);
    endtask
    // --------------------------------------------
    // scenarios
    // --------------------------------------------
    task s_refuse;
        chk(64'(prm), 64'(rst_prm));
        motion_running <= 1'b1;
        refused(KIND_RESTORE, 32'h0, 32'h0);
        motion_running <= 1'b0;
        refused(KIND_REF_RUN, 32'h72010056, 32'h78);
        refused(KIND_REF_RUN, 32'h72123412, 32'h34);
        chk(64'(reference_run_active), 64'h0);
        apb(1'b0, 8'h10, 32'h0);
        chk(64'({err, rd}), 64'({1'b1, 32'h0}));
    endtask
    task s_param;
        send(KIND_PARAM, 1'b1, 7'h15, 32'hA5C356B4, 32'hFB);
        chk(64'(prm), 64'({16'hA5C3, 11'h2B4, 1'b1, 4'h6, 1'b1, 2'b10}));
        send(KIND_PARAM, 1'b1, 7'h16, 32'h11223344, 32'hE3);
        chk(64'(prm), 64'({16'hA5C3, 11'h2B4, 1'b1, 4'h6, 1'b1, 2'b10}));
        send(KIND_PARAM, 1'b0, 7'h16, 32'h11223344, 32'hE3);
        chk(64'(prm), 64'({16'h1122, 11'h144, 1'b1, 4'h3, 1'b0, 2'b00}));
        apb(1'b0, REG_ARG, 32'h0);
        chk(64'({err, rd}), 64'h11223344);
    endtask
    task s_restore;
        send(KIND_RESTORE, 1'b0, 7'h7F, 32'h0, 32'h0);
        chk(64'(prm), 64'(rst_prm));
        chk(64'(restores), 64'h1);
        motion_running <= 1'b1;
        send(KIND_PARAM, 1'b1, 7'h15, 32'h11C32233, 32'hE3);
        chk(64'(prm), 64'({RST_RUN_CURRENT, RST_HOLD_CURRENT, 8'hC3, RST_SECURE_POSITION,
            RST_DIRECTION_INVERT, RST_ACCELERATION, RST_ACCEL_SHAPE, RST_MICROSTEP}));
        motion_running <= 1'b0;
    endtask
    task s_ref;
        send(KIND_REF_RUN, 1'b0, 7'h01, 32'h72123456, 32'h78);
        chk(64'({reference_run_active, reference_constant_speed, reference_target,
            reference_max_velocity, reference_min_velocity}), 64'({2'b10, 16'h1234, 8'h72}));
        pulse(1'b0);
        chk(64'(positioning_grant), 64'h0);
        pulse(1'b1);
        chk(64'({reference_run_active, reference_constant_speed, reference_target,
            reference_min_velocity}), 64'({2'b11, 16'h5678, 4'h2}));
        pulse(1'b1);
        @(posedge pclk);
        chk(64'({reference_run_active, reference_lockup}), 64'h0);
        pulse(1'b0);
        chk(64'(positioning_grant), 64'h1);
    endtask
    task s_otp;
        send(KIND_OTP, 1'b0, 7'h40, 32'h03A50000, 32'h0);
        while (otp_busy !== 1'b0) @(posedge pclk);
        chk(64'({otp_zapped, otp_image[39:32]}), 64'h08A5);
    endtask
    task s_lock;
        issue(KIND_REF_RUN, 1'b0, 7'h01, 32'h72222233, 32'h44);
        actual_position <= 16'h2222;
        repeat (3) @(posedge pclk);
        chk(64'({reference_lockup, reference_run_active}), 64'h2);
        presetn <= 1'b0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        repeat (2) @(posedge pclk);
        chk(64'({reference_lockup, prm}), 64'(rst_prm));
    endtask
    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (restore_done === 1'b1) restores <= restores + 1;
        if (cycles == 20000) begin
            mismatches++;
            close_out;
        end
    end
    initial begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        repeat (2) @(posedge pclk);
        s_refuse;
        s_param;
        s_restore;
        s_ref;
        s_otp;
        s_lock;
        close_out;
    end
endmodule
